// [design/acl_pkg.sv]
// Constants and types for the serial configuration load block
package acl_pkg;
  localparam int CFG_W = 12;
  localparam int CODE_W = 12;
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_CLKS = 5'h10;
  localparam logic [CNT_W-1:0] LOAD_EDGES = 5'h0C;
  localparam int LEAD_ZEROS = 2;
  localparam int COMMIT_POS = 11;
  localparam int SEQ_HI_POS = 10;
  localparam int CHAN_HI_POS = 7;
  localparam int CHAN_LO_POS = 6;
  localparam int PM_HI_POS = 5;
  localparam int PM_LO_POS = 4;
  localparam int SEQ_LO_POS = 3;
  localparam int SPAN_POS = 1;
  localparam int FMT_POS = 0;
  // Reset leaves the converter in normal power, channel 0, twos complement
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h030;
  localparam logic [FRAME_W-1:0] OUT_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

  typedef struct packed {
    logic commit;
    logic chan_order_ctrl_hi;
    logic [1:0] unused_hi;
    logic channel_sel_hi;
    logic channel_sel_lo;
    logic power_mode_hi;
    logic power_mode_lo;
    logic chan_order_ctrl_lo;
    logic unused_bit;
    logic span_sel;
    logic fmt_sel;
  } acl_cfg_t;

  typedef struct packed {
    logic [1:0] chan;
    logic [CODE_W-1:0] code;
  } acl_result_t;
endpackage : acl_pkg

// [design/acl_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module acl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : acl_sync
`default_nettype wire

// [design/acl_top.sv]
// Serial configuration load and result shift-out of a four-channel converter
`timescale 1ns/100ps
`default_nettype none
module acl_top
  import acl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial pins from the host
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_b,
  // Serial result pin
  output logic dout,
  output logic dout_oe,
  // Converter core side
  input wire logic conv_done,
  input wire logic [CODE_W-1:0] conv_code,
  output logic conv_start,
  output logic [1:0] conv_chan,
  output logic conv_span_sel,
  // Configuration in force
  output acl_cfg_t cfg,
  // Frame status
  output logic frame_short
);
  // Raw core code is straight binary; twos complement flips the MSB
  function automatic logic [CODE_W-1:0] fmt_code(input logic [CODE_W-1:0] raw, input logic binary);
    fmt_code = binary ? raw : {~raw[CODE_W-1], raw[CODE_W-2:0]};
  endfunction : fmt_code

  function automatic logic [1:0] chan_of(input acl_cfg_t c);
    chan_of = {c.channel_sel_hi, c.channel_sel_lo};
  endfunction : chan_of

  // Level-change decode; the fall test serves the select and serial clock pins, the rise test only the select pin
  function automatic logic fell_now(input logic was, input logic now);
    fell_now = was & ~now;
  endfunction : fell_now

  function automatic logic rose_now(input logic was, input logic now);
    rose_now = ~was & now;
  endfunction : rose_now

  // Synchronised pins; sclk may run at most about a quarter of core_clk
  logic [2:0] pins_s;
  logic sclk_s;
  logic din_s;
  logic cs_b_s;
  logic sclk_q;
  logic cs_b_q;

  acl_sync #(
    .W(3),
    .RESET_VAL(3'h5)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({sclk, din, cs_b}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign din_s = pins_s[1];
  assign cs_b_s = pins_s[0];

  // Frame and edge decode
  wire frame_on = ~cs_b_s;
  wire cs_fall = fell_now(cs_b_q, cs_b_s);
  wire cs_rise = rose_now(cs_b_q, cs_b_s);
  wire sclk_drop = fell_now(sclk_q, sclk_s);
  // An sclk edge in the cycle that opens the frame belongs to no frame
  wire sclk_fall = sclk_drop & frame_on & ~cs_fall;

  // Edge counting and input capture
  logic [CNT_W-1:0] edge_cnt;
  logic [CFG_W-2:0] in_sr;
  logic [CNT_W-1:0] next_edge_cnt;
  logic [CFG_W-1:0] next_word;
  logic [CFG_W-2:0] next_in_sr;

  wire capture_edge = sclk_fall && (edge_cnt < LOAD_EDGES);
  wire last_load_edge = sclk_fall && (edge_cnt == LOAD_EDGES - 5'h01);
  assign next_word = {in_sr, din_s};
  wire commit_load = last_load_edge && next_word[COMMIT_POS];

  // Saturates, so an overlong frame cannot wrap back into the load window
  assign next_edge_cnt = cs_fall ? CNT_RESET :
                         (sclk_fall && edge_cnt != CNT_MAX) ? edge_cnt + 5'h01 : edge_cnt;
  // A fresh frame starts from a clean shifter, whatever the last one left
  assign next_in_sr = cs_fall ? {(CFG_W-1){1'b0}} :
                      capture_edge ? next_word[CFG_W-2:0] : in_sr;

  // Edge history resets to the idle pin levels, so release shows no false edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      cs_b_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_b_q <= cs_b_s;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt <= CNT_RESET;
    end else begin
      edge_cnt <= next_edge_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_sr <= '0;
    end else begin
      in_sr <= next_in_sr;
    end
  end

  // Configuration register, never read back over the serial link
  // Bit 11 keeps the commit flag, so a loaded register always shows it set
  acl_cfg_t next_cfg;

  assign next_cfg = commit_load ? acl_cfg_t'(next_word) : cfg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= acl_cfg_t'(CFG_RESET);
    end else begin
      cfg <= next_cfg;
    end
  end

  // Conversion start and the settings it uses
  acl_cfg_t conv_cfg;
  acl_result_t last_result;
  acl_result_t next_result;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= cs_fall;
    end
  end

  // Settings are frozen at frame start, so a write inside the frame waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_cfg <= acl_cfg_t'(CFG_RESET);
    end else if (cs_fall) begin
      conv_cfg <= cfg;
    end
  end

  assign conv_chan = chan_of(conv_cfg);
  assign conv_span_sel = conv_cfg.span_sel;

  // Coding follows the settings of the conversion that made the result
  assign next_result = conv_done ?
                       acl_result_t'{chan: chan_of(conv_cfg), code: fmt_code(conv_code, conv_cfg.fmt_sel)} :
                       last_result;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_result <= '{chan: 2'h0, code: CODE_RESET};
    end else begin
      last_result <= next_result;
    end
  end

  // Result shift-out, loaded as the frame opens
  logic [FRAME_W-1:0] out_sr;
  logic [FRAME_W-1:0] next_out_sr;
  wire [FRAME_W-1:0] out_word = {{LEAD_ZEROS{1'b0}}, last_result.chan, last_result.code};

  assign next_out_sr = cs_fall ? out_word :
                       sclk_fall ? {out_sr[FRAME_W-2:0], 1'b0} : out_sr;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sr <= OUT_RESET;
    end else begin
      out_sr <= next_out_sr;
    end
  end

  // The pin keeps its last bit between frames; only dout_oe marks it valid
  assign dout = out_sr[FRAME_W-1];
  assign dout_oe = frame_on;

  // A frame that closes before sixteen clocks is flagged for one cycle
  logic next_frame_short;

  assign next_frame_short = cs_rise && (edge_cnt < FRAME_CLKS);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_short <= 1'b0;
    end else begin
      frame_short <= next_frame_short;
    end
  end
endmodule : acl_top
`default_nettype wire

// [tb/acl_host.sv]
// Host model: frames one transfer and collects the result stream
`timescale 1ns/100ps
`default_nettype none
module acl_host (
  // Clock and result pin
  input wire logic core_clk,
  input wire logic dout,
  // Serial pins to the block
  output logic sclk,
  output logic din,
  output logic cs_b
);
  logic [15:0] rx;
  initial begin
    sclk = 1'h1;
    din = 1'h0;
    cs_b = 1'h1;
  end
  // Half periods of 4 cycles stay clear of the synchroniser limit
  task automatic frame(input logic [15:0] word, input int falls);
    @(negedge core_clk);
    cs_b = 1'h0;
    din = word[15];
    for (int i = 0; i < falls; i++) begin
      repeat (4) @(negedge core_clk);
      rx = {rx[14:0], dout};
      sclk = 1'h0;
      repeat (4) @(negedge core_clk);
      sclk = 1'h1;
      din = (i < 15) ? word[14 - i] : ~din;
    end
    repeat (4) @(negedge core_clk);
    cs_b = 1'h1;
    // Released data line must not look like valid data
    din = ~din;
    repeat (4) @(negedge core_clk);
  endtask : frame
endmodule : acl_host
`default_nettype wire

// [tb/acl_top_sva.sv]
// Port assertions for the serial configuration load block
`timescale 1ns/100ps
`default_nettype none
module acl_top_sva
  import acl_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic dout_oe,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic conv_span_sel,
  input wire acl_cfg_t cfg,
  input wire logic frame_short
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_open;
    $fell(cs_b);
  endsequence
  sequence s_idle;
    cs_b [*4];
  endsequence
  chk_oe_open: assert property (s_open |-> ##[1:4] dout_oe) else $error("open late");
  chk_oe_idle: assert property (s_idle |-> !dout_oe) else $error("oe while idle");
  chk_start_follow: assert property ($rose(dout_oe) |=> conv_start) else $error("no start");
  chk_start_pulse: assert property (conv_start |=> !conv_start) else $error("start long");
  chk_chan_frozen: assert property ($changed(conv_chan) |-> conv_start) else $error("chan moved");
  chk_chan_taken: assert property (conv_start |->
    conv_chan == $past({cfg.channel_sel_hi, cfg.channel_sel_lo})) else $error("chan wrong");
  chk_span_taken: assert property (conv_start |-> conv_span_sel == $past(cfg.span_sel)) else $error("span wrong");
  chk_cfg_commit: assert property ($changed(cfg) |-> dout_oe && cfg.commit) else $error("bad load");
  chk_short_pulse: assert property (frame_short |=> !frame_short) else $error("short long");
endmodule : acl_top_sva
bind acl_top acl_top_sva u_sva (.core_clk, .rst_b, .cs_b, .dout_oe, .conv_start, .conv_chan, .conv_span_sel,
  .cfg, .frame_short);
`default_nettype wire

// [tb/acl_top_tb.sv]
// Testbench for the serial configuration load block
`timescale 1ns/100ps
`default_nettype none
module acl_top_tb;
  import acl_pkg::*;
  logic core_clk = 1'h0, rst_b = 1'h0, conv_done = 1'h0;
  logic dout, dout_oe, conv_start, conv_span_sel, frame_short;
  logic [CODE_W-1:0] conv_code = 12'h000;
  logic [1:0] conv_chan;
  acl_cfg_t cfg;
  wire logic sclk, din, cs_b;
  int err_total = 0;
  int checks_done = 0;
  int short_seen = 0;
  always #20 core_clk = ~core_clk;
  // Short-frame flags are counted away from the edge that launches them
  always @(negedge core_clk) begin
    if (frame_short === 1'b1) begin
      short_seen++;
    end
  end
  acl_host host (.core_clk, .dout, .sclk, .din, .cs_b);
  acl_top dut (.core_clk, .rst_b, .sclk, .din, .cs_b, .dout, .dout_oe, .conv_done, .conv_code, .conv_start,
    .conv_chan, .conv_span_sel, .cfg, .frame_short);
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic pulse(input logic [11:0] code);
    @(negedge core_clk);
    conv_code = code;
    conv_done = 1'h1;
    @(negedge core_clk);
    conv_done = 1'h0;
  endtask : pulse
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst_b = 1'h1;
    repeat (3) @(negedge core_clk);
    check(16'(cfg), 16'(CFG_RESET));
    // Trailing ones on falls 13 to 16 must be dropped
    host.frame(16'h8C3F, 16);
    check(16'(cfg), 16'h08C3);
    pulse(12'hA51);
    host.frame(16'h0FF0, 16);
    check(host.rx, 16'h0251);
    check(16'(cfg), 16'h08C3);
    pulse(12'hA51);
    host.frame(16'hFFF0, 8);
    check(16'(cfg), 16'h08C3);
    check(16'(short_seen), 16'h0001);
    host.frame(16'h8010, 16);
    check(host.rx, 16'h3A51);
    check(16'(cfg), 16'h0801);
    // The conversion opened by the writing frame still runs on channel 3
    pulse(12'h5AE);
    host.frame(16'h0000, 16);
    check(host.rx, 16'h35AE);
    check(16'(cfg), 16'h0801);
    check(16'(short_seen), 16'h0001);
    complete_run();
  end
endmodule : acl_top_tb
`default_nettype wire
